/* rtl/adcc_pkg.sv */
package adcc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus geometry
    localparam int unsigned ADCC_ADDR_W = 5;
    localparam int unsigned ADCC_DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [4:0] ADCC_OFS_CTRL    = 5'h00;
    localparam logic [4:0] ADCC_OFS_CLKSEL  = 5'h04;
    localparam logic [4:0] ADCC_OFS_PINCFG  = 5'h08;
    localparam logic [4:0] ADCC_OFS_RES_LO  = 5'h0c;
    localparam logic [4:0] ADCC_OFS_RES_HI  = 5'h10;
    localparam logic [4:0] ADCC_OFS_INTCTL  = 5'h14;
    localparam logic [4:0] ADCC_OFS_STATUS  = 5'h18;
    localparam logic [4:0] ADCC_OFS_MASK    = 5'h1c;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned ADCC_CTRL_START = 7;
    localparam int unsigned ADCC_CTRL_PEND  = 6;
    localparam int unsigned ADCC_CTRL_BUSY  = 5;
    localparam int unsigned ADCC_CLK_PD     = 6;
    localparam int unsigned ADCC_CLK_UNDEF  = 5;
    localparam int unsigned ADCC_INT_GIE    = 0;
    localparam int unsigned ADCC_INT_CIE    = 1;
    localparam int unsigned ADCC_INT_FLAG   = 2;
    localparam int unsigned ADCC_STS_DONE   = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam logic [2:0] ADCC_CHAN_RST    = 3'h0;
    localparam logic [2:0] ADCC_CLKDIV_RST  = 3'h0;
    localparam logic       ADCC_PD_RST      = 1'b1;
    localparam logic [7:0] ADCC_PINCFG_RST  = 8'h00;
    localparam logic       ADCC_PEND_RST    = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Counts
    localparam logic [4:0] ADCC_CONV_PERIODS = 5'h10;
    localparam int unsigned ADCC_RATIO_W     = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        ADCC_IDLE,
        ADCC_HOLD,
        ADCC_CONV
    } adcc_phase_e;

    typedef struct packed {
        logic [ADCC_RATIO_W-1:0] cnt;
        logic                    tick;
    } adcc_div_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic        start;
        logic        pend;
        logic [2:0]  chan;
        logic [2:0]  clkdiv;
        logic        pd;
        logic [7:0]  pin_cfg;
        logic        gie;
        logic        cie;
        logic        sts;
        logic        msk;
        logic [11:0] result;
        logic [4:0]  periods;
        adcc_phase_e phase;
        logic [7:0]  oe;
        logic [7:0]  pu;
        logic        irq;
    } adcc_state_s;

    // Zero marks the undefined clock select codes
    function automatic logic [ADCC_RATIO_W-1:0] adcc_div_ratio(input logic [2:0] sel);
        logic [ADCC_RATIO_W-1:0] r;
        r = '0;
        case (sel)
            3'h0:    r = 6'h02;
            3'h1:    r = 6'h08;
            3'h2:    r = 6'h20;
            3'h4:    r = 6'h01;
            3'h5:    r = 6'h04;
            3'h6:    r = 6'h10;
            default: r = 6'h00;
        endcase
        return r;
    endfunction

endpackage

/* rtl/adcc_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none

module adcc_clkdiv
    import adcc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] sel,
    // Converter clock period strobe
    output logic            tick
);

    adcc_div_s q;
    adcc_div_s d;
    logic [ADCC_RATIO_W-1:0] ratio;

    always_comb begin
        ratio  = adcc_div_ratio(sel);
        d      = q;
        d.tick = 1'b0;
        if (!run || ratio == '0) begin
            // Undefined codes give no periods, so a conversion stalls
            d.cnt = '0;
        end else if (q.cnt + 6'h01 >= ratio) begin
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

`default_nettype wire

/* rtl/adcc_top.sv */
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module adcc_top
    import adcc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Port pins shared with analog inputs
    input  wire logic [7:0]  port_dir_out,
    input  wire logic [7:0]  port_pullup_req,
    output logic [7:0]       port_drive_en,
    output logic [7:0]       port_pullup_en,
    output logic [7:0]       analog_pin_select,
    // Analog front end
    input  wire logic [11:0] conv_data,
    output logic [2:0]       channel_select,
    output logic             converter_enable,
    output logic             converter_hold,
    output logic             converter_sampling,
    // Processor side
    input  wire logic        return_stack_full,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    adcc_state_s q;
    adcc_state_s d;
    logic        period_tick;
    logic        req;
    logic        acc_wr;
    logic        acc_rd;
    logic        wr_lane0;
    logic        new_start;
    logic        undef_sel;

    adcc_clkdiv u_clkdiv (
        .clk    (clk),
        .arst_n (arst_n),
        .run    (q.phase == ADCC_CONV),
        .sel    (q.clkdiv),
        .tick   (period_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d         = q;
        req       = (avs_read | avs_write) & ~q.ack;
        acc_wr    = avs_write & q.ack;
        acc_rd    = avs_read & q.ack;
        wr_lane0  = acc_wr & avs_byteenable[0];
        new_start = avs_writedata[ADCC_CTRL_START];
        undef_sel = (adcc_div_ratio(q.clkdiv) == '0);
        d.ack     = req;

        // Read data is fetched one cycle early so it stands at the accepting edge
        if (req && avs_read) begin
            d.rdata = '0;
            case (avs_address)
                ADCC_OFS_CTRL: begin
                    d.rdata[ADCC_CTRL_START] = q.start;
                    d.rdata[ADCC_CTRL_PEND]  = q.pend;
                    d.rdata[ADCC_CTRL_BUSY]  = (q.phase == ADCC_CONV);
                    d.rdata[2:0]             = q.chan;
                end
                ADCC_OFS_CLKSEL: begin
                    d.rdata[ADCC_CLK_PD]    = q.pd;
                    d.rdata[ADCC_CLK_UNDEF] = undef_sel;
                    d.rdata[2:0]            = q.clkdiv;
                end
                ADCC_OFS_PINCFG: begin
                    d.rdata[7:0] = q.pin_cfg;
                end
                ADCC_OFS_RES_LO: begin
                    d.rdata[7:0] = q.result[7:0];
                end
                ADCC_OFS_RES_HI: begin
                    d.rdata[3:0] = q.result[11:8];
                end
                ADCC_OFS_INTCTL: begin
                    d.rdata[ADCC_INT_GIE]  = q.gie;
                    d.rdata[ADCC_INT_CIE]  = q.cie;
                    d.rdata[ADCC_INT_FLAG] = q.sts;
                end
                ADCC_OFS_STATUS: begin
                    d.rdata[ADCC_STS_DONE] = q.sts;
                end
                ADCC_OFS_MASK: begin
                    d.rdata[ADCC_STS_DONE] = q.msk;
                end
                default: begin
                    d.rdata = '0;
                end
            endcase
        end

        // Register writes take effect at the accepting edge only
        if (wr_lane0) begin
            case (avs_address)
                ADCC_OFS_CTRL: begin
                    d.chan  = avs_writedata[2:0];
                    d.start = new_start;
                    if (new_start) begin
                        // High start keeps the converter parked in reset
                        d.phase   = ADCC_HOLD;
                        d.pend    = 1'b1;
                        d.periods = '0;
                    end else if (q.start && !q.pd) begin
                        // Falling edge ends the pulse and launches
                        d.phase   = ADCC_CONV;
                        d.pend    = 1'b1;
                        d.periods = '0;
                    end else if (q.start) begin
                        d.phase = ADCC_IDLE;
                    end
                end
                ADCC_OFS_CLKSEL: begin
                    d.clkdiv = avs_writedata[2:0];
                    d.pd     = avs_writedata[ADCC_CLK_PD];
                end
                ADCC_OFS_PINCFG: begin
                    d.pin_cfg = avs_writedata[7:0];
                end
                ADCC_OFS_INTCTL: begin
                    d.gie = avs_writedata[ADCC_INT_GIE];
                    d.cie = avs_writedata[ADCC_INT_CIE];
                end
                ADCC_OFS_MASK: begin
                    d.msk = avs_writedata[ADCC_STS_DONE];
                end
                default: begin
                end
            endcase
        end

        // Reading status clears the sticky flag
        if (acc_rd && avs_address == ADCC_OFS_STATUS) begin
            d.sts = 1'b0;
        end

        // Powering down abandons a running conversion; the flag stays high
        if (d.pd && d.phase == ADCC_CONV) begin
            d.phase = ADCC_IDLE;
        end

        // Conversion proceeds on its own; the bus never waits on it
        if (q.phase == ADCC_CONV && d.phase == ADCC_CONV && period_tick) begin
            if (q.periods == ADCC_CONV_PERIODS - 5'h01) begin
                d.phase   = ADCC_IDLE;
                d.periods = '0;
                d.pend    = 1'b0;
                d.result  = conv_data;
                // Set wins over a same-cycle read clear
                d.sts     = 1'b1;
            end else begin
                d.periods = q.periods + 5'h01;
            end
        end

        // Analog selection strips pull-up and output driver
        d.pu  = port_pullup_req & ~q.pin_cfg;
        d.oe  = port_dir_out & ~q.pin_cfg;

        // Polling the pending flag works with every enable off
        d.irq = q.sts & q.msk & q.gie & q.cie & ~return_stack_full;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q         <= '0;
            q.pend    <= ADCC_PEND_RST;
            q.chan    <= ADCC_CHAN_RST;
            q.clkdiv  <= ADCC_CLKDIV_RST;
            q.pd      <= ADCC_PD_RST;
            q.pin_cfg <= ADCC_PINCFG_RST;
            q.phase   <= ADCC_IDLE;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata       = q.rdata;
    assign avs_waitrequest    = (avs_read | avs_write) & ~q.ack;
    assign port_drive_en      = q.oe;
    assign port_pullup_en     = q.pu;
    assign analog_pin_select  = q.pin_cfg;
    assign channel_select     = q.chan;
    assign converter_enable   = ~q.pd;
    assign converter_hold     = (q.phase == ADCC_HOLD);
    assign converter_sampling = (q.phase == ADCC_CONV);
    assign irq                = q.irq;

endmodule

`default_nettype wire

/* testbench/adcc_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module adcc_analog_model
    import adcc_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Converter side
    input  wire logic [2:0]  channel_select,
    input  wire logic        converter_sampling,
    output logic [11:0]      conv_data
);
    initial conv_data = 12'h000;
    // Input n gives its own code; outside sampling the line toggles so stale data shows
    always @(posedge clk) begin
        conv_data <= converter_sampling ? {channel_select, 9'h0a5} : ~conv_data;
    end
endmodule

`default_nettype wire

/* testbench/adcc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module adcc_monitor (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Bus handshake
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic       avs_waitrequest,
    // Pins
    input  wire logic [7:0] port_dir_out,
    input  wire logic [7:0] port_pullup_req,
    input  wire logic [7:0] port_drive_en,
    input  wire logic [7:0] port_pullup_en,
    input  wire logic [7:0] analog_pin_select,
    // Converter and processor
    input  wire logic       converter_enable,
    input  wire logic       converter_hold,
    input  wire logic       converter_sampling,
    input  wire logic       return_stack_full,
    input  wire logic       irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Override is registered, so the pins follow one cycle behind
    AST_DRIVE: assert property (
        $past(arst_n) |-> port_drive_en == $past(port_dir_out & ~analog_pin_select))
        else $error("drive enable wrong");
    AST_PULLUP: assert property (
        $past(arst_n) |-> port_pullup_en == $past(port_pullup_req & ~analog_pin_select))
        else $error("pull-up enable wrong");
    AST_WAIT: assert property (
        $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer late");
    AST_HOLD: assert property (
        converter_hold |-> !converter_sampling)
        else $error("sampling during hold");
    AST_LAUNCH: assert property (
        $fell(converter_hold) && converter_enable |-> converter_sampling)
        else $error("no launch on start fall");
    AST_ONLY: assert property (
        $rose(converter_sampling) |-> $fell(converter_hold))
        else $error("launch without start pulse");
    AST_PD: assert property (
        !converter_enable |-> !converter_sampling)
        else $error("sampling while powered down");
    AST_STACK: assert property (
        return_stack_full |=> !irq)
        else $error("irq with full stack");

    cover property ($rose(irq));
    cover property ($fell(converter_sampling) && !converter_hold);
    cover property ($fell(converter_enable));
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import adcc_pkg::*;
;
    logic        clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [7:0]  port_dir_out = 8'h00, port_pullup_req = 8'h00, port_drive_en, port_pullup_en;
    logic [7:0]  analog_pin_select, pcfg;
    logic [11:0] conv_data;
    logic [2:0]  channel_select, ch;
    logic        converter_enable, converter_hold, converter_sampling, irq, avs_waitrequest;
    logic        return_stack_full = 1'b0;
    logic [2:0]  sel_t [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int          per_t [6] = '{2, 8, 32, 1, 4, 16};
    int          num_errors = 0, n_tests = 0, seed = 57, cyc = 0, cnt;
    logic [31:0] exp_q [$], msk_q [$];
    string       nam_q [$];

    always #2 clk = ~clk;

    adcc_top dut (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .port_dir_out(port_dir_out), .port_pullup_req(port_pullup_req),
        .port_drive_en(port_drive_en), .port_pullup_en(port_pullup_en), .analog_pin_select(analog_pin_select),
        .conv_data(conv_data), .channel_select(channel_select), .converter_enable(converter_enable),
        .converter_hold(converter_hold), .converter_sampling(converter_sampling),
        .return_stack_full(return_stack_full), .irq(irq));

    adcc_analog_model u_ana (.clk(clk), .channel_select(channel_select),
        .converter_sampling(converter_sampling), .conv_data(conv_data));

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // For reads d is the expected value; the watcher compares it
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d, input string n = "",
                       input logic [31:0] m = 32'h0);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        if (!w) begin
            exp_q.push_back(d & m);
            msk_q.push_back(m);
            nam_q.push_back(n);
        end
        @(posedge clk iff avs_waitrequest === 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            check(nam_q.pop_front(), avs_readdata & msk_q.pop_front(), exp_q.pop_front());
        end
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end

    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        acc(0, ADCC_OFS_CTRL, 32'h40, "ctrl_rst", 32'hc7);
        acc(0, ADCC_OFS_CLKSEL, 32'h40, "clk_rst", 32'h47);
        acc(0, 5'h1e, 32'h0, "unmapped", 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            pcfg = 8'($random(seed));
            port_dir_out    <= 8'($random(seed));
            port_pullup_req <= 8'($random(seed));
            acc(1, ADCC_OFS_PINCFG, {24'h0, pcfg});
            acc(0, ADCC_OFS_PINCFG, {24'h0, pcfg}, "pin_cfg", 32'hff);
            check("pin_sel", 32'(analog_pin_select), 32'(pcfg));
            check("drive_en", 32'(port_drive_en), 32'(port_dir_out & ~pcfg));
            check("pullup_en", 32'(port_pullup_en), 32'(port_pullup_req & ~pcfg));
        end
        // Irq raised once, in pass 1; the other passes are masked, enable off or stack full
        for (int i = 0; i < 6; i++) begin
            ch = 3'(i + 2);
            return_stack_full <= (i == 5);
            acc(1, ADCC_OFS_MASK, {31'h0, i != 3});
            acc(1, ADCC_OFS_INTCTL, {30'h0, i[0], 1'b1});
            acc(1, ADCC_OFS_CLKSEL, {29'h0, sel_t[i]});
            acc(1, ADCC_OFS_CTRL, {24'h0, 5'h10, ch});
            acc(0, ADCC_OFS_CTRL, {24'h0, 5'h18, ch}, "ctrl_hold", 32'hc7);
            check("hold", 32'(converter_hold), 32'h1);
            acc(1, ADCC_OFS_CTRL, {29'h0, ch});
            cnt = 0;
            @(posedge clk);
            while (converter_sampling === 1'b1 && cnt < 1000) begin
                cnt++;
                @(posedge clk);
            end
            check("conv_len", 32'(cnt >= 16 * per_t[i] && cnt <= 16 * per_t[i] + 2), 32'h1);
            repeat (3) @(posedge clk);
            check("irq", 32'(irq), 32'(i == 1));
            acc(0, ADCC_OFS_CTRL, {29'h0, ch}, "ctrl_done", 32'hc7);
            acc(0, ADCC_OFS_RES_LO, 32'ha5, "res_lo", 32'hffffffff);
            acc(0, ADCC_OFS_RES_HI, {28'h0, ch, 1'b0}, "res_hi", 32'hffffffff);
            acc(0, ADCC_OFS_INTCTL, {29'h1, i[0], 1'b1}, "int_flag", 32'h7);
            acc(0, ADCC_OFS_STATUS, 32'h1, "sts_set", 32'h1);
            acc(0, ADCC_OFS_STATUS, 32'h0, "sts_clr", 32'h1);
            check("irq_clr", 32'(irq), 32'h0);
        end
        // Channel back to zero needs no start pulse; the flag keeps its value
        acc(1, ADCC_OFS_CTRL, 32'h00);
        acc(0, ADCC_OFS_CTRL, 32'h00, "ctrl_chan0", 32'hc7);
        // Power-down in mid-conversion must abort it
        acc(1, ADCC_OFS_CLKSEL, 32'h02);
        acc(1, ADCC_OFS_CTRL, 32'h80);
        acc(1, ADCC_OFS_CTRL, 32'h00);
        acc(0, ADCC_OFS_CTRL, 32'h60, "ctrl_busy", 32'he7);
        acc(1, ADCC_OFS_CLKSEL, 32'h42);
        acc(0, ADCC_OFS_CLKSEL, 32'h42, "clk_pd", 32'h47);
        check("enable_pd", 32'(converter_enable), 32'h0);
        repeat (16 * 32 + 8) @(posedge clk);
        acc(0, ADCC_OFS_STATUS, 32'h0, "sts_abort", 32'h1);
        acc(0, ADCC_OFS_CTRL, 32'h40, "ctrl_abort", 32'hc7);
        acc(1, ADCC_OFS_CLKSEL, 32'h03);
        acc(0, ADCC_OFS_CLKSEL, 32'h23, "clk_undef", 32'h67);
        print_verdict();
    end
endmodule

bind adcc_top adcc_monitor u_mon (.clk(clk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .port_dir_out(port_dir_out), .port_pullup_req(port_pullup_req),
    .port_drive_en(port_drive_en), .port_pullup_en(port_pullup_en), .analog_pin_select(analog_pin_select),
    .converter_enable(converter_enable), .converter_hold(converter_hold),
    .converter_sampling(converter_sampling), .return_stack_full(return_stack_full), .irq(irq));

`default_nettype wire
